//--- bst_tap_defs.vh
/*
  Constants for the boundary-scan test access port: state codes, instruction
  encodings, register lengths and identification field layout.
  Assumes inclusion by the port logic and its bench; definitions only.
*/
`ifndef BST_TAP_DEFS_VH
`define BST_TAP_DEFS_VH

// ----------------------------------------
// Register lengths
// ----------------------------------------
`define BST_IR_W 3
`define BST_ID_W 32
`define BST_BSR_W 109
`define BST_RESET_HIGHS 5

// ----------------------------------------
// Instruction codes
// ----------------------------------------
`define BST_OP_EXTEST 3'h0
`define BST_OP_IDCODE 3'h1
`define BST_OP_SAMPLE 3'h2
`define BST_OP_BYPASS 3'h7
`define BST_IR_CAPTURE 3'h1

// ----------------------------------------
// Controller states
// ----------------------------------------
`define BST_S_RESET 4'h0
`define BST_S_IDLE 4'h1
`define BST_S_SELDR 4'h2
`define BST_S_CAPDR 4'h3
`define BST_S_SHDR 4'h4
`define BST_S_EX1DR 4'h5
`define BST_S_PAUSEDR 4'h6
`define BST_S_EX2DR 4'h7
`define BST_S_UPDDR 4'h8
`define BST_S_SELIR 4'h9
`define BST_S_CAPIR 4'ha
`define BST_S_SHIR 4'hb
`define BST_S_EX1IR 4'hc
`define BST_S_PAUSEIR 4'hd
`define BST_S_EX2IR 4'he
`define BST_S_UPDIR 4'hf

// ----------------------------------------
// Identification fields (values arbitrary)
// ----------------------------------------
`define BST_ID_REV 4'h1
`define BST_ID_PART 16'h0abc
`define BST_ID_VENDOR 11'h055

`endif

//--- bst_tap.v
/*
  Boundary-scan test access port, clocked by the system clock, which
  oversamples the test clock pin and acts on its detected edges.
  Assumes the test clock is far slower than clock (at least 4 clocks per
  half period) and that pinRing carries the pad levels to be captured.
*/
// What this block does
// - Only the basic scan instruction subset
// - Sample on rising, drive out on falling
// - State and instruction select serial register
// - Five high mode-select edges reach reset
// - Power-up forces the reset state
// - Instruction loads only in instruction path
// - Identify instruction preloaded at reset
// - One-bit bypass register between data pins
// - Capture loads 32-bit identification code
// - Identification register shifts in shift-DR
// - Capture samples the pin ring
// - Boundary register shifts, selected by EXTEST and SAMPLE
// - Each boundary bit maps to fixed bump
// - Three-bit instruction register
// - Boundary register holds 109 cells
// - Identification code field layout
`timescale 1ns/10ps
`include "bst_tap_defs.vh"

module bst_tap #(
  parameter BSR_W = `BST_BSR_W,
  parameter [3:0] ID_REV = `BST_ID_REV,
  parameter [15:0] ID_PART = `BST_ID_PART,
  parameter [10:0] ID_VENDOR = `BST_ID_VENDOR
) (
  input wire clock,
  input wire rst_n,
  input wire testClk,
  input wire modeSel,
  input wire dataIn,
  input wire [BSR_W-1:0] pinRing,
  output reg dataOut_q,
  output reg dataOutEn_n_q,
  output wire [`BST_IR_W-1:0] activeInstr
);

  // ----------------------------------------
  // Controller state codes
  // ----------------------------------------
  localparam [3:0] S_RESET = `BST_S_RESET;
  localparam [3:0] S_IDLE = `BST_S_IDLE;
  localparam [3:0] S_SELDR = `BST_S_SELDR;
  localparam [3:0] S_CAPDR = `BST_S_CAPDR;
  localparam [3:0] S_SHDR = `BST_S_SHDR;
  localparam [3:0] S_EX1DR = `BST_S_EX1DR;
  localparam [3:0] S_PAUSEDR = `BST_S_PAUSEDR;
  localparam [3:0] S_EX2DR = `BST_S_EX2DR;
  localparam [3:0] S_UPDDR = `BST_S_UPDDR;
  localparam [3:0] S_SELIR = `BST_S_SELIR;
  localparam [3:0] S_CAPIR = `BST_S_CAPIR;
  localparam [3:0] S_SHIR = `BST_S_SHIR;
  localparam [3:0] S_EX1IR = `BST_S_EX1IR;
  localparam [3:0] S_PAUSEIR = `BST_S_PAUSEIR;
  localparam [3:0] S_EX2IR = `BST_S_EX2IR;
  localparam [3:0] S_UPDIR = `BST_S_UPDIR;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg [2:0] tckSync_q;
  reg [2:0] tmsSync_q;
  reg [2:0] tdiSync_q;
  reg tckLevel_q;
  reg tmsLevel_q;
  reg tdiLevel_q;

  // A change counts only once stages two and three agree
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tckSync_q <= 3'h0;
      tmsSync_q <= 3'h0;
      tdiSync_q <= 3'h0;
      tckLevel_q <= 1'b0;
      tmsLevel_q <= 1'b0;
      tdiLevel_q <= 1'b0;
    end
    else
    begin
      tckSync_q <= {tckSync_q[1:0], testClk};
      tmsSync_q <= {tmsSync_q[1:0], modeSel};
      tdiSync_q <= {tdiSync_q[1:0], dataIn};
      if (tckSync_q[1] == tckSync_q[2])
        tckLevel_q <= tckSync_q[2];
      if (tmsSync_q[1] == tmsSync_q[2])
        tmsLevel_q <= tmsSync_q[2];
      if (tdiSync_q[1] == tdiSync_q[2])
        tdiLevel_q <= tdiSync_q[2];
    end
  end

  wire tckRise = (tckSync_q[1] == tckSync_q[2]) && tckSync_q[2] && !tckLevel_q;
  wire tckFall = (tckSync_q[1] == tckSync_q[2]) && !tckSync_q[2] && tckLevel_q;
  wire tms = tmsLevel_q;
  wire tdi = tdiLevel_q;

  // Pad levels pass the same filter; a capture sees the ring a few clocks late
  wire [BSR_W-1:0] pinLevel;
  genvar gi;
  generate
    for (gi = 0; gi < BSR_W; gi = gi + 1)
    begin : g_pinSync
      reg [2:0] pinSync_q;
      reg pinLevel_q;
      always @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
        begin
          pinSync_q <= 3'h0;
          pinLevel_q <= 1'b0;
        end
        else
        begin
          pinSync_q <= {pinSync_q[1:0], pinRing[gi]};
          if (pinSync_q[1] == pinSync_q[2])
            pinLevel_q <= pinSync_q[2];
        end
      end
      assign pinLevel[gi] = pinLevel_q;
    end
  endgenerate

  // ----------------------------------------
  // Controller state machine
  // ----------------------------------------
  reg [3:0] state_q;
  reg [3:0] state_d;

  // Mode select is the only steering input
  always @*
  begin
    state_d = state_q;
    case (state_q)
      S_RESET: state_d = tms ? S_RESET : S_IDLE;
      S_IDLE: state_d = tms ? S_SELDR : S_IDLE;
      S_SELDR: state_d = tms ? S_SELIR : S_CAPDR;
      S_CAPDR: state_d = tms ? S_EX1DR : S_SHDR;
      S_SHDR: state_d = tms ? S_EX1DR : S_SHDR;
      S_EX1DR: state_d = tms ? S_UPDDR : S_PAUSEDR;
      S_PAUSEDR: state_d = tms ? S_EX2DR : S_PAUSEDR;
      S_EX2DR: state_d = tms ? S_UPDDR : S_SHDR;
      S_UPDDR: state_d = tms ? S_SELDR : S_IDLE;
      S_SELIR: state_d = tms ? S_RESET : S_CAPIR;
      S_CAPIR: state_d = tms ? S_EX1IR : S_SHIR;
      S_SHIR: state_d = tms ? S_EX1IR : S_SHIR;
      S_EX1IR: state_d = tms ? S_UPDIR : S_PAUSEIR;
      S_PAUSEIR: state_d = tms ? S_EX2IR : S_PAUSEIR;
      S_EX2IR: state_d = tms ? S_UPDIR : S_SHIR;
      S_UPDIR: state_d = tms ? S_SELDR : S_IDLE;
      default: state_d = S_RESET;
    endcase
  end

  // ----------------------------------------
  // Scan registers
  // ----------------------------------------
  // Bit 0 of each shift register sits next to the data output
  reg [`BST_IR_W-1:0] irShift_q;
  reg [`BST_IR_W-1:0] instr_q;
  reg bypass_q;
  reg [`BST_ID_W-1:0] idShift_q;
  reg [BSR_W-1:0] bsr_q;

  wire [`BST_ID_W-1:0] idCode = {ID_REV, ID_PART, ID_VENDOR, 1'b1};

  // Unknown codes fall back to bypass so a chain never breaks
  wire selId = (instr_q == `BST_OP_IDCODE);
  wire selBsr = (instr_q == `BST_OP_EXTEST) || (instr_q == `BST_OP_SAMPLE);
  wire selByp = !selId && !selBsr;

  assign activeInstr = instr_q;

  // Power-up reset puts the controller in reset with identify loaded
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= S_RESET;
      instr_q <= `BST_OP_IDCODE;
      irShift_q <= `BST_IR_CAPTURE;
      bypass_q <= 1'b0;
      idShift_q <= {`BST_ID_W{1'b0}};
      bsr_q <= {BSR_W{1'b0}};
    end
    else if (tckRise)
    begin
      state_q <= state_d;
      // Identify takes effect on the very edge that enters reset
      if (state_d == S_RESET)
        instr_q <= `BST_OP_IDCODE;
      case (state_q)
        S_RESET: instr_q <= `BST_OP_IDCODE;
        S_CAPIR: irShift_q <= `BST_IR_CAPTURE;
        S_SHIR: irShift_q <= {tdi, irShift_q[`BST_IR_W-1:1]};
        S_UPDIR: instr_q <= irShift_q;
        S_CAPDR:
        begin
          bypass_q <= 1'b0;
          if (selId)
            idShift_q <= idCode;
          if (selBsr)
            bsr_q <= pinLevel;
        end
        S_SHDR:
        begin
          if (selByp)
            bypass_q <= tdi;
          if (selId)
            idShift_q <= {tdi, idShift_q[`BST_ID_W-1:1]};
          if (selBsr)
            bsr_q <= {tdi, bsr_q[BSR_W-1:1]};
        end
        default: bypass_q <= bypass_q;
      endcase
    end
  end

  // ----------------------------------------
  // Serial output, launched on the falling edge
  // ----------------------------------------
  reg tdoBit;
  always @*
  begin
    if (selId)
      tdoBit = idShift_q[0];
    else if (selBsr)
      tdoBit = bsr_q[0];
    else
      tdoBit = bypass_q;
    if (state_q == S_SHIR)
      tdoBit = irShift_q[0];
  end

  wire shifting = (state_q == S_SHIR) || (state_q == S_SHDR);

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dataOut_q <= 1'b0;
      dataOutEn_n_q <= 1'b1;
    end
    else if (tckFall)
    begin
      dataOut_q <= tdoBit;
      dataOutEn_n_q <= !shifting;
    end
  end

endmodule // bst_tap

//--- bst_tap_checker.sv
/* Port timing checker for bst_tap.
   Assumes test clock half periods of 8 clocks and bind by name. */
`timescale 1ns/10ps
module bst_tap_checker (
  input wire clock,
  input wire rst_n,
  input wire testClk,
  input wire modeSel,
  input wire dataOut_q,
  input wire dataOutEn_n_q,
  input wire [2:0] activeInstr
);
  reg [2:0] highCnt_q;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Saturates at five so a long high run stays visible
  always @(posedge clock or negedge rst_n)
    if (!rst_n)
      highCnt_q <= 3'h0;
    else if ($rose(testClk))
      highCnt_q <= modeSel ? highCnt_q + {2'h0, highCnt_q != 3'h5} : 3'h0;
  chk_reset_id: assert property
    ($rose(rst_n) |-> activeInstr == 3'h1 && dataOutEn_n_q) else $error("bad reset");
  chk_five_high: assert property
    (highCnt_q == 3'h5 |-> ##6 activeInstr == 3'h1) else $error("no scan reset");
  chk_out_fall: assert property
    ($changed(dataOut_q) |-> !$past(testClk, 2) && $past(testClk, 7)) else $error("out edge");
  chk_en_fall: assert property
    ($changed(dataOutEn_n_q) |-> !$past(testClk, 2) && $past(testClk, 7)) else $error("en edge");
  chk_instr_rise: assert property
    ($changed(activeInstr) |-> $past(testClk, 2) && !$past(testClk, 7)) else $error("ir edge");
  chk_instr_path: assert property
    ($changed(activeInstr) |-> dataOutEn_n_q) else $error("ir in shift");
  chk_en_hold: assert property
    ($fell(dataOutEn_n_q) |-> !dataOutEn_n_q [*8]) else $error("en short");
  chk_out_hold: assert property
    ($changed(dataOut_q) |=> $stable(dataOut_q) [*8]) else $error("out short");
endmodule // bst_tap_checker
bind bst_tap bst_tap_checker bst_tap_checker_i (.clock(clock), .rst_n(rst_n),
  .testClk(testClk), .modeSel(modeSel), .dataOut_q(dataOut_q),
  .dataOutEn_n_q(dataOutEn_n_q), .activeInstr(activeInstr));

//--- bst_scan_master.sv
/* Scan controller model driving the test port pins.
   Assumes clock is the 100 MHz system clock. */
`timescale 1ns/10ps
module bst_scan_master (
  input wire clock,
  input wire dataOut_q,
  output logic testClk,
  output logic modeSel,
  output logic dataIn
);
  initial {testClk, modeSel, dataIn} = 3'h2;
  // Test clock stands low between frames; 8 clocks each half keeps setup and hold
  task step(input logic m, input logic d, output logic q);
    @(posedge clock);
    #1 modeSel = m;
    dataIn = d;
    repeat (7) @(posedge clock);
    #1 testClk = 1'b1;
    q = dataOut_q;
    repeat (8) @(posedge clock);
    #1 testClk = 1'b0;
  endtask
  task reset5;
    logic q;
    repeat (5) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask
endmodule // bst_scan_master

//--- test_bst_tap.sv
/* Self-checking bench for bst_tap.
   Assumes the controller model bst_scan_master paces the test clock. */
`timescale 1ns/10ps
`include "bst_tap_defs.vh"
module test_bst_tap;
  logic clock, rst_n;
  logic [108:0] pinRing, got;
  wire testClk, modeSel, dataIn, dataOut_q, dataOutEn_n_q;
  wire [2:0] activeInstr;
  int n_mismatch, n_checks, cyc;
  bst_scan_master bst_scan_master_i (.clock(clock), .dataOut_q(dataOut_q),
    .testClk(testClk), .modeSel(modeSel), .dataIn(dataIn));
  bst_tap bst_tap_i (.clock(clock), .rst_n(rst_n), .testClk(testClk), .modeSel(modeSel),
    .dataIn(dataIn), .pinRing(pinRing), .dataOut_q(dataOut_q),
    .dataOutEn_n_q(dataOutEn_n_q), .activeInstr(activeInstr));
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task check(input logic [108:0] seen, exp);
    n_checks++;
    n_mismatch += (seen !== exp);
    if (seen !== exp) $display("[FAIL] %0t got %h", $time, seen);
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task st(input logic m);
    logic q;
    bst_scan_master_i.step(m, 1'b0, q);
  endtask
  // Shift n bits from capture, out bits land in got; ends in idle
  task shift(input int n, input logic [108:0] v);
    st(1'b0);
    for (int i = 0; i < n; i++) bst_scan_master_i.step(i == n - 1, v[i], got[i]);
    check(dataOutEn_n_q, 1'b0);
    st(1'b1);
    check(dataOutEn_n_q, 1'b1);
    st(1'b0);
  endtask
  task ir(input logic [2:0] c);
    st(1'b1);
    st(1'b1);
    st(1'b0);
    shift(3, {106'h0, c});
    check(got[2:0], `BST_IR_CAPTURE);
    check(activeInstr, c);
  endtask
  task dr(input int n, input logic [108:0] v);
    st(1'b1);
    st(1'b0);
    shift(n, v);
  endtask
  task t_powerup;
    check(dataOutEn_n_q, 1'b1);
    check(dataOut_q, 1'b0);
    check(activeInstr, `BST_OP_IDCODE);
    bst_scan_master_i.reset5;
    check(activeInstr, `BST_OP_IDCODE);
    $display("powerup done");
  endtask
  task t_ident;
    dr(32, '0);
    check(got[31:0], {`BST_ID_REV, `BST_ID_PART, `BST_ID_VENDOR, 1'b1});
    $display("ident done");
  endtask
  task t_bypass;
    for (int c = 3; c < 8; c++)
    begin
      ir(c[2:0]);
      dr(4, 109'hb);
      check(got[3:0], 4'h6);
    end
    $display("bypass done");
  endtask
  task t_boundary;
    for (int k = 0; k < 2; k++)
    begin
      pinRing = {{54{2'h1}}, 1'b1} ^ {109{k[0]}};
      ir(k[0] ? `BST_OP_SAMPLE : `BST_OP_EXTEST);
      dr(109, '0);
      check(got, pinRing);
    end
    $display("boundary done");
  endtask
  task t_reset;
    ir(`BST_OP_BYPASS);
    st(1'b1);
    st(1'b0);
    bst_scan_master_i.reset5;
    check(activeInstr, `BST_OP_IDCODE);
    ir(`BST_OP_BYPASS);
    st(1'b1);
    st(1'b0);
    st(1'b0);
    st(1'b0);
    check(dataOutEn_n_q, 1'b0);
    rst_n = 1'b0;
    @(posedge clock);
    #1 rst_n = 1'b1;
    check(activeInstr, `BST_OP_IDCODE);
    check(dataOutEn_n_q, 1'b1);
    $display("reset done");
  endtask
  initial
  begin
    rst_n = 1'b0;
    pinRing = '0;
    repeat (5) @(posedge clock);
    #1 rst_n = 1'b1;
    t_powerup;
    t_ident;
    t_bypass;
    t_boundary;
    t_reset;
    finish_test;
  end
  // About 6550 cycles expected; limit leaves room
  always @(posedge clock)
    if (++cyc == 20000)
    begin
      n_mismatch++;
      finish_test;
    end
endmodule // test_bst_tap
